// ### tb/blit_list_engine_tb.sv
// Self-checking bench of the blit list engine against a reference blitter
`timescale 1ns/1ps

module blit_list_engine_tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic listStart = 1'b0;
  logic [23:0] listBase = 24'h00_0000;
  logic listIrqEnable = 1'b0;
  logic [1:0] ackDelay = 2'h0;
  logic slowMem = 1'b0;
  logic memReq, memWrite, memAck, busy, listDone, listIrq, collisionSeen;
  logic [23:0] memAddr;
  logic [7:0] memWdata, memRdata, collisionCode, refCode;
  logic [7:0] refMem [int];
  logic [7:0] rec [21];
  logic refSeen;
  logic [2:0] lastMode;
  integer seed = 44;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;

  blu_engine DUT (.ref_clk(ref_clk), .rst(rst), .listStart(listStart), .listBase(listBase),
    .listIrqEnable(listIrqEnable), .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr),
    .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata), .busy(busy),
    .listDone(listDone), .listIrq(listIrq), .collisionSeen(collisionSeen),
    .collisionCode(collisionCode));
  blu_mem_model memModel (.ref_clk(ref_clk), .rst(rst), .memReq(memReq), .memWrite(memWrite),
    .memAddr(memAddr), .memWdata(memWdata), .ackDelay(ackDelay), .memAck(memAck),
    .memRdata(memRdata));

  always #20 ref_clk = ~ref_clk;

  // Ceiling well above ten lists of the sizes drawn below
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    ackDelay <= slowMem ? 2'($random(seed)) : 2'h0;
    if (cycles == 90000) begin
      miscompares = miscompares + 1;
      conclude();
    end
  end

  task automatic conclude();
    if (miscompares == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic [7:0] rd(input logic [23:0] a);
    return refMem.exists(int'(a)) ? refMem[int'(a)] : 8'h00;
  endfunction : rd

  task automatic poke(input logic [23:0] a, input logic [7:0] v);
    refMem[int'(a)] = v;
    memModel.mem[int'(a)] = v;
  endtask : poke

  // ----------------------------------------------------------------
  // Reference blitter
  // ----------------------------------------------------------------
  function automatic logic [7:0] combine(input logic [2:0] m, input logic [7:0] s,
                                         input logic [7:0] d);
    case (m)
      3'h1: return (s != 8'h00) ? s : d;
      3'h2: return s + d;
      3'h3: return s | d;
      3'h4: return s & d;
      3'h5: return s ^ d;
      3'h6: return {(s[7:4] != 4'h0) ? s[7:4] : d[7:4], (s[3:0] != 4'h0) ? s[3:0] : d[3:0]};
      default: return s;
    endcase
  endfunction : combine

  function automatic logic collide(input logic [2:0] m, input logic [7:0] s,
                                   input logic [7:0] d, input logic [7:0] k);
    if (m == 3'h6) begin
      return (s[7:4] != 4'h0 && d[7:4] != 4'h0 && k[d[7:5]]) ||
             (s[3:0] != 4'h0 && d[3:0] != 4'h0 && k[d[3:1]]);
    end
    return m != 3'h0 && s != 8'h00 && d != 8'h00 && k[d[7:5]];
  endfunction : collide

  task automatic run_ref(input logic [23:0] base);
    logic [23:0] a, sRow, dRow, sa, da;
    logic [12:0] sy, dy;
    logic [7:0] s, d;
    int w, h, zx, zy, pl, pi;
    logic more;
    a = base;
    more = 1'b1;
    while (more) begin
      for (int i = 0; i < 21; i++) rec[i] = rd(a + 24'(i));
      sRow = {rec[2], rec[1], rec[0]};
      dRow = {rec[8], rec[7], rec[6]};
      sy = {rec[4][4:0], rec[3]};
      dy = {rec[10][4:0], rec[9]};
      w = {rec[13][0], rec[12]} + 1;
      h = rec[14] + 1;
      zx = rec[18][2:0] + 1;
      zy = rec[18][6:4] + 1;
      pl = rec[19][5:0] + 1;
      refSeen = 1'b0;
      lastMode = rec[20][2:0];
      for (int y = 0; y < h; y++) begin
        for (int ry = 0; ry < zy; ry++) begin
          sa = sRow;
          da = dRow;
          pi = 0;
          for (int x = 0; x < w; x++) begin
            s = (rd(sa) & rec[15]) ^ rec[16];
            for (int rx = 0; rx < zx; rx++) begin
              d = rd(da);
              if (!refSeen && collide(lastMode, s, d, rec[17])) begin
                refSeen = 1'b1;
                refCode = d;
                if (lastMode == 3'h6) begin
                  refCode = (s[7:4] != 4'h0 && d[7:4] != 4'h0 && rec[17][d[7:5]]) ?
                            {d[7:4], 4'h0} : {4'h0, d[3:0]};
                end
              end
              refMem[int'(da)] = combine(lastMode, s, d);
              da = da + {{16{rec[11][7]}}, rec[11]};
            end
            pi = pi + 1;
            if (rec[19][7] && pi == pl) begin
              pi = 0;
              sa = sRow;
            end else begin
              sa = sa + {{16{rec[5][7]}}, rec[5]};
            end
          end
          dRow = dRow + {{11{dy[12]}}, dy};
        end
        sRow = sRow + {{11{sy[12]}}, sy};
      end
      more = rec[20][3];
      a = a + 24'd21;
    end
  endtask : run_ref

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  task automatic make_list(input int it, input logic [23:0] base, input int nrec);
    logic [23:0] src, dst;
    logic [12:0] sy, dy;
    logic [7:0] sx, dx, zm, pt, hm;
    logic [8:0] wm;
    logic [167:0] r;
    for (int n = 0; n < nrec; n++) begin
      src = 24'h01_0000 + 24'(it * 4096 + n * 1024);
      dst = 24'h40_0000 + 24'(it * 4096 + n * 1024);
      for (int i = -512; i < 512; i++) begin
        poke(src + 24'(i), 8'($random(seed)));
        poke(dst + 24'(i), 8'($random(seed)));
      end
      sy = 13'($random(seed) % 40);
      dy = 13'($random(seed) % 40);
      sx = 8'($random(seed) % 3);
      dx = 8'($random(seed) % 3);
      wm = 9'($unsigned($random(seed)) % 6);
      hm = 8'($unsigned($random(seed)) % 3);
      zm = {1'b0, 3'($unsigned($random(seed)) % 3), 1'b0, 3'($unsigned($random(seed)) % 3)};
      pt = {1'($random(seed)), 1'b0, 6'($unsigned($random(seed)) % 4)};
      if (it == 0) begin
        wm = 9'h1FF;
        zm = 8'h00;
        sx = 8'h00;
        dx = 8'h01;
        hm = 8'h00;
      end else if (it == 1) begin
        zm = 8'h77;
        dx = 8'hFF;
        hm = 8'h00;
      end else if (it == 2) begin
        wm = 9'h045;
        pt = 8'hBF;
        sx = 8'h01;
        dx = 8'h01;
        zm = 8'h00;
      end
      r = {4'h0, 1'(n != nrec - 1), 3'((it * 3 + n) % 8), pt, zm, 8'($random(seed)),
           8'($random(seed) & $random(seed)), 8'($random(seed) & $random(seed) & $random(seed)),
           hm, 7'h00, wm, dx, 3'h0, dy, dst, sx, 3'h0, sy, src};
      for (int k = 0; k < 21; k++) poke(base + 24'(n * 21 + k), r[8*k +: 8]);
    end
  endtask : make_list

  task automatic run_list(input int it);
    logic [23:0] base;
    int guard;
    base = 24'h00_1000 + 24'(it * 128);
    make_list(it, base, (it < 3) ? 1 : 1 + int'($unsigned($random(seed)) % 3));
    run_ref(base);
    slowMem <= it[0];
    listIrqEnable <= it[1];
    @(posedge ref_clk);
    listStart <= 1'b1;
    listBase <= base;
    @(posedge ref_clk);
    listStart <= 1'b0;
    listBase <= 24'($random(seed));
    @(negedge ref_clk);
    check("busy on trigger", busy, 1);
    check("first fetch address", memAddr, base);
    @(posedge ref_clk);
    listStart <= 1'b1;
    @(posedge ref_clk);
    listStart <= 1'b0;
    guard = 0;
    while (listDone !== 1'b1 && guard < 20000) begin
      @(negedge ref_clk);
      guard++;
    end
    check("list finished", listDone, 1);
    check("busy at list end", busy, 0);
    check("list interrupt", listIrq, it[1]);
    check("collision flag", collisionSeen, refSeen);
    if (refSeen) begin
      check("collision code", collisionCode, refCode);
    end
    @(negedge ref_clk);
    check("done pulse", listDone, 0);
    check("access after end", memReq, 0);
    check("bytes stored", memModel.mem.num(), refMem.num());
    foreach (refMem[a]) check("memory byte", memModel.mem[a], refMem[a]);
  endtask : run_list

  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    check("busy after reset", busy, 0);
    check("request after reset", memReq, 0);
    for (int it = 0; it < 10; it++) begin
      run_list(it);
    end
    conclude();
  end
endmodule : blit_list_engine_tb

// ### tb/blu_mem_model.sv
// Behavioural local memory answering the engine with a variable delay
`timescale 1ns/1ps

module blu_mem_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic memReq,
  input wire logic memWrite,
  input wire logic [23:0] memAddr,
  input wire logic [7:0] memWdata,
  input wire logic [1:0] ackDelay,
  output logic memAck,
  output logic [7:0] memRdata
);
  logic [7:0] mem [int];
  logic [1:0] waitQ;

  function automatic logic [7:0] peek(input int a);
    return mem.exists(a) ? mem[a] : 8'h00;
  endfunction : peek

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      memAck <= 1'b0;
      memRdata <= 8'h00;
      waitQ <= 2'h0;
    end else if (memAck) begin
      // Read data is only good in the ack cycle; garbage afterwards
      memAck <= 1'b0;
      memRdata <= ~memRdata;
      waitQ <= ackDelay;
      if (memReq && memWrite) begin
        mem[int'(memAddr)] = memWdata;
      end
    end else if (memReq && waitQ == 2'h0) begin
      memAck <= 1'b1;
      memRdata <= memWrite ? ~memRdata : peek(int'(memAddr));
    end else if (memReq) begin
      waitQ <= waitQ - 2'h1;
    end
  end
endmodule : blu_mem_model

// ### verilog/blu_combine.sv
// Per-byte combine of source and destination, with collision detection
`timescale 1ns/1ps
`include "blu_defines.svh"

module blu_combine (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [2:0] mode,
  input wire logic [7:0] src,
  input wire logic [7:0] dst,
  input wire logic [7:0] collMask,
  output logic [7:0] result,
  output logic writeEn,
  output logic collHit,
  output logic [7:0] collValue
);
  import blu_pkg::*;

  logic hiHit;
  logic loHit;
  logic byteHit;

  always_comb begin
    result = src;
    writeEn = 1'b1;
    unique case (mode)
      `BLU_MODE_COPY: result = src; // RULE13
      `BLU_MODE_STENCIL: writeEn = (src != 8'h00); // RULE14
      `BLU_MODE_ADD: result = 8'(src + dst); // RULE15 RULE22
      `BLU_MODE_OR: result = src | dst; // RULE15
      `BLU_MODE_AND: result = src & dst; // RULE15
      `BLU_MODE_XOR: result = src ^ dst; // RULE15
      `BLU_MODE_NIBBLE: begin
        result[7:4] = (src[7:4] != 4'h0) ? src[7:4] : dst[7:4]; // RULE14
        result[3:0] = (src[3:0] != 4'h0) ? src[3:0] : dst[3:0]; // RULE14
      end
      default: result = src;
    endcase
  end

  // ----------------------------------------------------------------
  // Collision: opaque source over opaque destination in an enabled group
  // ----------------------------------------------------------------
  always_comb begin
    byteHit = (src != 8'h00) && (dst != 8'h00) && collMask[dst[7:5]]; // RULE20
    hiHit = (src[7:4] != 4'h0) && (dst[7:4] != 4'h0) && collMask[dst[7:5]]; // RULE20
    loHit = (src[3:0] != 4'h0) && (dst[3:0] != 4'h0) && collMask[dst[3:1]]; // RULE20
    collHit = 1'b0;
    collValue = dst;
    if (mode == `BLU_MODE_NIBBLE) begin
      collHit = hiHit || loHit;
      collValue = hiHit ? {dst[7:4], 4'h0} : {4'h0, dst[3:0]};
    end else if (mode != `BLU_MODE_COPY) begin
      collHit = byteHit;
    end
  end

  a_add_wraps: assert property (@(posedge ref_clk) disable iff (rst) // RULE22
    mode == `BLU_MODE_ADD |-> result == 8'(src + dst))
    else $error("add result does not wrap modulo 256");
  a_nibble_keep: assert property (@(posedge ref_clk) disable iff (rst) // RULE14
    (mode == `BLU_MODE_NIBBLE && src[3:0] == 4'h0) |-> result[3:0] == dst[3:0])
    else $error("nibble stencil overwrote a kept destination nibble");

endmodule : blu_combine

// ### verilog/blu_defines.svh
// Constants of the blit list engine: record layout, field positions, mode codes
`ifndef BLU_DEFINES_SVH
`define BLU_DEFINES_SVH

// ----------------------------------------------------------------
// Record layout
// ----------------------------------------------------------------
`define BLU_REC_BYTES 21
`define BLU_REC_LAST 5'h14
`define BLU_REC_STRIDE 24'h00_0015
`define BLU_OFS_SRC0 0
`define BLU_OFS_SRC1 1
`define BLU_OFS_SRC2 2
`define BLU_OFS_SRCY0 3
`define BLU_OFS_SRCY1 4
`define BLU_OFS_SRCX 5
`define BLU_OFS_DST0 6
`define BLU_OFS_DST1 7
`define BLU_OFS_DST2 8
`define BLU_OFS_DSTY0 9
`define BLU_OFS_DSTY1 10
`define BLU_OFS_DSTX 11
`define BLU_OFS_WID0 12
`define BLU_OFS_WID1 13
`define BLU_OFS_HGT 14
`define BLU_OFS_AND 15
`define BLU_OFS_XOR 16
`define BLU_OFS_COLL 17
`define BLU_OFS_ZOOM 18
`define BLU_OFS_PAT 19
`define BLU_OFS_CTRL 20

// ----------------------------------------------------------------
// Field positions and mode codes
// ----------------------------------------------------------------
`define BLU_PAT_EN_BIT 7
`define BLU_NEXT_BIT 3
`define BLU_MODE_COPY 3'h0
`define BLU_MODE_STENCIL 3'h1
`define BLU_MODE_ADD 3'h2
`define BLU_MODE_OR 3'h3
`define BLU_MODE_AND 3'h4
`define BLU_MODE_XOR 3'h5
`define BLU_MODE_NIBBLE 3'h6

`endif

// ### verilog/blu_engine.sv
// Blit list engine: fetches setup records and walks source/destination rectangles
// Functional notes
// RULE1: Fetch 21-byte records from a contiguous list
// RULE2: 24-bit start addresses, low byte first
// RULE3: Row steps are 13-bit signed values
// RULE4: Signed 8-bit column step after each byte
// RULE5: Start addresses first; rows add row step
// RULE6: Zero and negative steps are honoured
// RULE7: Width 9-bit minus one, height 8-bit
// RULE8: Source AND mask, then XOR mask
// RULE9: Zoom repeats bytes and rows, up to 8
// RULE10: Size counts source bytes and rows
// RULE11: Pattern mode repeats first row bytes
// RULE12: Pattern repetition applies after zoom
// RULE13: Seven modes; mode 0 plain copy
// RULE14: Byte and nibble stencils skip zero source
// RULE15: Modes 2-5 add, OR, AND, XOR
// RULE16: Next bit chains to following record
// RULE17: Optional interrupt when list completes
// RULE18: Only local memory is accessed
// RULE19: Host places list, sets start, triggers
// RULE20: Collision mask enables eight destination groups
// RULE21: First collision captures destination into code
// RULE22: Addition wraps modulo 256
// RULE23: Busy from trigger to last write
`timescale 1ns/1ps
`include "blu_defines.svh"

module blu_engine (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic listStart,
  input wire logic [23:0] listBase,
  input wire logic listIrqEnable,
  output logic memReq,
  output logic memWrite,
  output logic [23:0] memAddr,
  output logic [7:0] memWdata,
  input wire logic memAck,
  input wire logic [7:0] memRdata,
  output logic busy,
  output logic listDone,
  output logic listIrq,
  output logic collisionSeen,
  output logic [7:0] collisionCode
);
  import blu_pkg::*;

  blu_core_t s_q;
  blu_core_t s_d;
  logic [8*`BLU_REC_BYTES-1:0] recBytes;
  logic recWr;
  logic adv;
  logic [7:0] cmbResult;
  logic cmbWrite;
  logic cmbHit;
  logic [7:0] cmbValue;

  // ----------------------------------------------------------------
  // Record fields
  // ----------------------------------------------------------------
  function automatic logic [7:0] recByte(input int idx);
    recByte = recBytes[idx*8 +: 8];
  endfunction : recByte

  logic [23:0] srcStart;
  logic [23:0] dstStart;
  logic [23:0] srcDy;
  logic [23:0] dstDy;
  logic [23:0] srcDx;
  logic [23:0] dstDx;
  logic [8:0] widthM1;
  logic [7:0] heightM1;
  logic [7:0] andMask;
  logic [7:0] xorMask;
  logic [7:0] collMask;
  logic [2:0] zoomXM1;
  logic [2:0] zoomYM1;
  logic pattern_repeat_enable;
  logic [5:0] patLenM1;
  logic [2:0] mode;
  logic chainNext;
  logic [7:0] srcMasked;

  always_comb begin
    srcStart = {recByte(`BLU_OFS_SRC2), recByte(`BLU_OFS_SRC1), recByte(`BLU_OFS_SRC0)}; // RULE2
    dstStart = {recByte(`BLU_OFS_DST2), recByte(`BLU_OFS_DST1), recByte(`BLU_OFS_DST0)}; // RULE2
    srcDy = {{11{recBytes[`BLU_OFS_SRCY1*8+4]}}, recBytes[`BLU_OFS_SRCY1*8 +: 5],
             recByte(`BLU_OFS_SRCY0)}; // RULE3
    dstDy = {{11{recBytes[`BLU_OFS_DSTY1*8+4]}}, recBytes[`BLU_OFS_DSTY1*8 +: 5],
             recByte(`BLU_OFS_DSTY0)}; // RULE3
    srcDx = {{16{recBytes[`BLU_OFS_SRCX*8+7]}}, recByte(`BLU_OFS_SRCX)}; // RULE4
    dstDx = {{16{recBytes[`BLU_OFS_DSTX*8+7]}}, recByte(`BLU_OFS_DSTX)}; // RULE4
    widthM1 = {recBytes[`BLU_OFS_WID1*8], recByte(`BLU_OFS_WID0)}; // RULE7
    heightM1 = recByte(`BLU_OFS_HGT); // RULE7
    andMask = recByte(`BLU_OFS_AND);
    xorMask = recByte(`BLU_OFS_XOR);
    collMask = recByte(`BLU_OFS_COLL);
    zoomXM1 = recBytes[`BLU_OFS_ZOOM*8 +: 3];
    zoomYM1 = recBytes[`BLU_OFS_ZOOM*8+4 +: 3];
    pattern_repeat_enable = recBytes[`BLU_OFS_PAT*8+`BLU_PAT_EN_BIT];
    patLenM1 = recBytes[`BLU_OFS_PAT*8 +: 6];
    mode = recBytes[`BLU_OFS_CTRL*8 +: 3];
    chainNext = recBytes[`BLU_OFS_CTRL*8+`BLU_NEXT_BIT];
    srcMasked = (memRdata & andMask) ^ xorMask; // RULE8
  end

  blu_rec_store #(
    .NBYTES(`BLU_REC_BYTES)
  ) uRec (
    .ref_clk(ref_clk),
    .rst(rst),
    .wrEn(recWr),
    .wrIdx(s_q.fetchIdx),
    .wrData(memRdata),
    .recBytes(recBytes)
  );

  blu_combine uCmb (
    .ref_clk(ref_clk),
    .rst(rst),
    .mode(mode),
    .src(s_q.srcByte),
    .dst(memRdata),
    .collMask(collMask),
    .result(cmbResult),
    .writeEn(cmbWrite),
    .collHit(cmbHit),
    .collValue(cmbValue)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Every access goes out on the one local memory port; the engine has
  // no path to any other space, so it cannot touch main memory.
  always_comb begin
    s_d = s_q;
    s_d.doneP = 1'b0;
    recWr = 1'b0;
    adv = 1'b0;
    unique case (s_q.st)
      ST_IDLE: begin
        if (listStart) begin // RULE19
          s_d.listPtr = listBase;
          s_d.fetchIdx = 5'h00;
          s_d.busy = 1'b1; // RULE23
          s_d.memReq = 1'b1; // RULE18
          s_d.memWe = 1'b0;
          s_d.memAddr = listBase;
          s_d.st = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (memAck) begin
          recWr = 1'b1; // RULE1
          if (s_q.fetchIdx == `BLU_REC_LAST) begin
            s_d.memReq = 1'b0;
            s_d.st = ST_SETUP;
          end else begin
            s_d.fetchIdx = s_q.fetchIdx + 5'h01;
            s_d.memAddr = s_q.memAddr + 24'h00_0001; // RULE1
          end
        end
      end
      ST_SETUP: begin
        s_d.srcRow = srcStart; // RULE5
        s_d.srcPtr = srcStart;
        s_d.dstRow = dstStart;
        s_d.dstPtr = dstStart;
        s_d.xCount = 9'h000;
        s_d.yCount = 8'h00;
        s_d.xZoom = 3'h0;
        s_d.yZoom = 3'h0;
        s_d.patIdx = 6'h00;
        s_d.collSeen = 1'b0;
        s_d.memReq = 1'b1;
        s_d.memWe = 1'b0;
        s_d.memAddr = srcStart; // RULE5
        s_d.st = ST_RD_SRC;
      end
      ST_RD_SRC: begin
        if (memAck) begin
          s_d.srcByte = srcMasked; // RULE8
          if (mode == `BLU_MODE_COPY) begin
            s_d.memWe = 1'b1;
            s_d.memWdata = srcMasked; // RULE13
            s_d.st = ST_WRITE;
          end else begin
            s_d.st = ST_RD_DST; // RULE15
          end
          s_d.memAddr = s_q.dstPtr;
        end
      end
      ST_RD_DST: begin
        if (memAck) begin
          if (cmbHit && !s_q.collSeen) begin
            s_d.collSeen = 1'b1; // RULE21
            s_d.collCode = cmbValue; // RULE21
          end
          if (cmbWrite) begin
            s_d.memWe = 1'b1;
            s_d.memWdata = cmbResult;
            s_d.st = ST_WRITE;
          end else begin
            adv = 1'b1; // RULE14
          end
        end
      end
      ST_WRITE: begin
        if (memAck) begin
          adv = 1'b1;
        end
      end
    endcase

    // Step to the next destination byte once the current one is settled
    if (adv) begin
      s_d.memWe = 1'b0;
      s_d.memReq = 1'b1;
      s_d.dstPtr = s_q.dstPtr + dstDx; // RULE4 RULE6 RULE9
      if (s_q.xZoom != zoomXM1) begin
        // Horizontal zoom reuses the held source byte instead of re-reading
        s_d.xZoom = s_q.xZoom + 3'h1; // RULE9 RULE12
        s_d.memAddr = s_d.dstPtr;
        if (mode == `BLU_MODE_COPY) begin
          s_d.memWe = 1'b1;
          s_d.memWdata = s_q.srcByte;
          s_d.st = ST_WRITE;
        end else begin
          s_d.st = ST_RD_DST;
        end
      end else if (s_q.xCount != widthM1) begin
        s_d.xZoom = 3'h0;
        s_d.xCount = s_q.xCount + 9'h001; // RULE10
        if (pattern_repeat_enable && (s_q.patIdx == patLenM1)) begin
          s_d.srcPtr = s_q.srcRow; // RULE11
          s_d.patIdx = 6'h00;
        end else begin
          s_d.srcPtr = s_q.srcPtr + srcDx; // RULE4 RULE6
          s_d.patIdx = s_q.patIdx + 6'h01;
        end
        s_d.memAddr = s_d.srcPtr;
        s_d.st = ST_RD_SRC;
      end else begin
        s_d.xZoom = 3'h0;
        s_d.xCount = 9'h000;
        s_d.patIdx = 6'h00;
        s_d.dstRow = s_q.dstRow + dstDy; // RULE5 RULE9
        s_d.dstPtr = s_d.dstRow;
        if (s_q.yZoom != zoomYM1) begin
          s_d.yZoom = s_q.yZoom + 3'h1; // RULE9
          s_d.srcPtr = s_q.srcRow;
          s_d.memAddr = s_q.srcRow;
          s_d.st = ST_RD_SRC;
        end else if (s_q.yCount != heightM1) begin
          s_d.yZoom = 3'h0;
          s_d.yCount = s_q.yCount + 8'h01; // RULE10
          s_d.srcRow = s_q.srcRow + srcDy; // RULE5 RULE6
          s_d.srcPtr = s_d.srcRow;
          s_d.memAddr = s_d.srcRow;
          s_d.st = ST_RD_SRC;
        end else if (chainNext) begin
          s_d.listPtr = s_q.listPtr + `BLU_REC_STRIDE; // RULE16
          s_d.fetchIdx = 5'h00;
          s_d.memAddr = s_d.listPtr;
          s_d.st = ST_FETCH;
        end else begin
          s_d.memReq = 1'b0;
          s_d.busy = 1'b0; // RULE23
          s_d.doneP = 1'b1; // RULE17
          s_d.st = ST_IDLE;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_q <= '{st: ST_IDLE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign memReq = s_q.memReq;
  assign memWrite = s_q.memWe;
  assign memAddr = s_q.memAddr;
  assign memWdata = s_q.memWdata;
  assign busy = s_q.busy;
  assign listDone = s_q.doneP;
  assign listIrq = s_q.doneP && listIrqEnable; // RULE17
  assign collisionSeen = s_q.collSeen;
  assign collisionCode = s_q.collCode;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_write_done;
    s_q.st == ST_WRITE && memAck;
  endsequence

  sequence s_src_taken;
    s_q.st == ST_RD_SRC && memAck;
  endsequence

  a_fetch_linear: assert property (@(posedge ref_clk) disable iff (rst) // RULE1
    (s_q.st == ST_FETCH && memAck && s_q.fetchIdx != `BLU_REC_LAST)
      |=> memAddr == $past(memAddr) + 24'h00_0001)
    else $error("record bytes not fetched back to back");
  a_first_source: assert property (@(posedge ref_clk) disable iff (rst) // RULE5
    s_q.st == ST_SETUP |=> (memAddr == $past(srcStart) && memReq && !memWrite))
    else $error("first access is not the source start address");
  a_mask_order: assert property (@(posedge ref_clk) disable iff (rst) // RULE8
    s_src_taken |=> s_q.srcByte == (($past(memRdata) & andMask) ^ xorMask))
    else $error("source byte not masked AND then XOR");
  a_zoom_reuse: assert property (@(posedge ref_clk) disable iff (rst) // RULE9
    (s_write_done and (s_q.xZoom != zoomXM1))
      |=> (s_q.st != ST_RD_SRC && memAddr == $past(s_q.dstPtr) + dstDx))
    else $error("horizontal zoom did not repeat the held byte");
  a_stencil_skip: assert property (@(posedge ref_clk) disable iff (rst) // RULE14
    (memReq && memWrite && mode == `BLU_MODE_STENCIL) |-> memWdata != 8'h00)
    else $error("byte stencil wrote a zero source");
  a_busy_span: assert property (@(posedge ref_clk) disable iff (rst) // RULE23
    (s_q.st == ST_IDLE && listStart) |=> busy [*2])
    else $error("busy not raised on trigger");
  a_done_clears: assert property (@(posedge ref_clk) disable iff (rst) // RULE23
    listDone |-> (!busy && !memReq && ($past(s_q.st) == ST_WRITE || $past(s_q.st) == ST_RD_DST)))
    else $error("list completion without busy falling");
  a_collision_once: assert property (@(posedge ref_clk) disable iff (rst) // RULE21
    (s_q.collSeen && s_q.st != ST_SETUP) |=> $stable(collisionCode))
    else $error("collision code overwritten within a blit");
  a_chain_next: assert property (@(posedge ref_clk) disable iff (rst) // RULE16
    ($past(s_q.st) != ST_IDLE && s_q.st == ST_FETCH && $past(s_q.st) != ST_FETCH)
      |-> memAddr == $past(s_q.listPtr) + `BLU_REC_STRIDE)
    else $error("chained record not fetched right after the previous one");

endmodule : blu_engine

// ### verilog/blu_pkg.sv
// Types shared by the blit list engine modules
package blu_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH,
    ST_SETUP,
    ST_RD_SRC,
    ST_RD_DST,
    ST_WRITE
  } blu_state_t;

  typedef struct packed {
    blu_state_t st;
    logic [4:0] fetchIdx;
    logic [23:0] listPtr;
    logic [23:0] srcRow;
    logic [23:0] dstRow;
    logic [23:0] srcPtr;
    logic [23:0] dstPtr;
    logic [8:0] xCount;
    logic [7:0] yCount;
    logic [2:0] xZoom;
    logic [2:0] yZoom;
    logic [5:0] patIdx;
    logic [7:0] srcByte;
    logic memReq;
    logic memWe;
    logic [23:0] memAddr;
    logic [7:0] memWdata;
    logic busy;
    logic collSeen;
    logic [7:0] collCode;
    logic doneP;
  } blu_core_t;

  typedef struct packed {
    logic [8*21-1:0] bytes;
  } blu_rec_t;

endpackage : blu_pkg

// ### verilog/blu_rec_store.sv
// Holds the 21 bytes of the blit record being executed
`timescale 1ns/1ps
`include "blu_defines.svh"

module blu_rec_store #(
  parameter int NBYTES = `BLU_REC_BYTES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic wrEn,
  input wire logic [4:0] wrIdx,
  input wire logic [7:0] wrData,
  output logic [8*NBYTES-1:0] recBytes
);
  import blu_pkg::*;

  logic [8*NBYTES-1:0] rec_q;
  logic [8*NBYTES-1:0] rec_d;

  // ----------------------------------------------------------------
  // One byte lane per record entry
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NBYTES; gi++) begin : gLane
      always_comb begin
        rec_d[gi*8 +: 8] = rec_q[gi*8 +: 8];
        if (wrEn && (wrIdx == 5'(gi))) begin
          rec_d[gi*8 +: 8] = wrData; // RULE1
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rec_q <= '0;
    end else begin
      rec_q <= rec_d;
    end
  end

  assign recBytes = rec_q;

endmodule : blu_rec_store
